// file: hdl/ess_core_state.sv
// machine state, exception and machine check syndrome registers
`timescale 1ns/10ps
`include "ess_defs.svh"

module ess_core_state
  import ess_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire ess_reg_acc_type reg_acc,
  input wire ess_instr_type instr,
  input wire ess_storage_evt_type storage_evt,
  input wire ess_mc_src_type mc_src,
  input wire logic mchk_taken,
  input wire logic crit_in,
  input wire logic wdog_evt,
  input wire logic ext_in,
  input wire logic dec_evt,
  input wire logic fit_evt,
  input wire logic debug_evt,
  input wire logic sleep_req,
  output logic [31:0] rdata,
  output ess_exc_req_type exc_req,
  output ess_irq_type irq_req,
  output logic mc_event_out,
  output logic power_save_ok,
  output logic fetch_space,
  output logic data_space,
  output logic user_mode
);

  logic [31:0] ms_r;
  logic [31:0] ms_nxt;
  logic [31:0] es_r;
  logic [31:0] es_nxt;
  logic [31:0] mc_r;
  logic [31:0] mc_nxt;
  logic mc_pin_prev_r;
  logic [31:0] rdata_nxt;
  ess_exc_req_type exc_nxt;
  ess_irq_type irq_nxt;

  // register selects
  wire logic sel_ms = reg_acc.is_state;
  wire logic sel_es = !reg_acc.is_state &&
                      reg_acc.spr == `ESS_SPR_EXC_SYNDROME;
  wire logic sel_mc = !reg_acc.is_state &&
                      reg_acc.spr == `ESS_SPR_MC_SYNDROME;
  wire logic wr_ms = reg_acc.wr && sel_ms;
  wire logic wr_es = reg_acc.wr && sel_es;
  wire logic wr_mc = reg_acc.wr && sel_mc;

  // state bits that steer the rest of the block
  wire logic cur_user = ms_r[`ESS_MS_USER_MODE_STATE];
  wire logic cur_lock_en = ms_r[`ESS_MS_USER_CACHE_LOCK_ENABLE];
  wire logic cur_vec_en = ms_r[`ESS_MS_VECTOR_SIMD_AVAILABLE];
  wire logic cur_float_en = ms_r[`ESS_MS_FLOAT_AVAILABLE];
  wire logic cur_mchk_en = ms_r[`ESS_MS_MACHINE_CHECK_ENABLE];

  // instruction permission checks, privilege checked first
  wire logic iv = instr.valid;
  wire logic chk_priv = iv && instr.privileged && cur_user;
  wire logic chk_lock = iv && !chk_priv && instr.cache_lock &&
                        cur_user && !cur_lock_en;
  wire logic chk_vec = iv && !chk_priv && !chk_lock && instr.vector_op &&
                       !cur_vec_en;
  wire logic chk_fpu = iv && !chk_priv && !chk_lock && !chk_vec &&
                       instr.float_op && !cur_float_en;
  wire logic chk_fpi = iv && !chk_priv && !chk_lock && !chk_vec &&
                       instr.float_op && cur_float_en;
  wire logic chk_any = chk_priv || chk_lock || chk_vec || chk_fpu || chk_fpi;

  // storage exceptions from the memory side
  wire logic sto_data = storage_evt.align_err || storage_evt.dsi_access ||
                        storage_evt.dtlb_miss || storage_evt.byte_order_dsi;
  wire logic sto_any = sto_data || storage_evt.mismatch_isi;

  // syndrome for the exception being raised; it replaces the old contents
  logic [31:0] es_hw;
  always_comb begin
    es_hw = 32'h00000000;
    es_hw[`ESS_ES_PPR] = chk_priv;
    es_hw[`ESS_ES_ICACHE_LOCK_FLAG] = chk_lock && instr.lock_icache;
    // data lock flag left clear by hardware, software may store it
    es_hw[`ESS_ES_VECTOR_OP] = chk_vec;
    es_hw[`ESS_ES_FLOAT_OP] = chk_fpi;
    es_hw[`ESS_ES_PUO] = chk_fpi;
    if (!chk_any) begin
      es_hw[`ESS_ES_BYTE_ORDER_FLAG] = storage_evt.byte_order_dsi ||
                                       storage_evt.mismatch_isi;
      es_hw[`ESS_ES_WRITE_ACCESS_FLAG] = sto_data &&
                                         storage_evt.is_store;
    end
  end

  // hardware update wins over a software write in the same cycle
  assign es_nxt = (chk_any || sto_any) ? es_hw :
                  wr_es ? (reg_acc.wdata & `ESS_ES_MASK) : es_r;

  // state register: masked writes, machine check entry drops recoverable bit
  always_comb begin
    ms_nxt = wr_ms ? (reg_acc.wdata & `ESS_MS_MASK) : ms_r;
    if (mchk_taken) begin
      ms_nxt[`ESS_MS_RECOVERABLE_INTERRUPT] = 1'b0;
    end
  end

  // machine check sources, the pin counts on its rising edge only
  logic [31:0] mc_set;
  always_comb begin
    mc_set = 32'h00000000;
    mc_set[`ESS_MC_PIN] = mc_src.pin && !mc_pin_prev_r;
    mc_set[`ESS_MC_ICACHE_DATA_PARITY_ERR] = mc_src.ic_data_parity;
    mc_set[`ESS_MC_ICACHE_TAG_PARITY_ERR] = mc_src.ic_tag_parity;
    mc_set[`ESS_MC_HANDLER_FETCH] = mc_src.handler_fetch;
    mc_set[`ESS_MC_IC_LOCKED_INVAL] = mc_src.locked_inval;
  end

  // write one to clear; a new event in the same cycle wins the clear
  wire logic [31:0] mc_clr = wr_mc ? reg_acc.wdata : 32'h00000000;
  assign mc_nxt = ((mc_r & ~mc_clr) | mc_set) & `ESS_MC_MASK;

  // pending async causes; the status bit never requests an interrupt
  wire logic mc_pend = |(mc_r & `ESS_MC_ASYNC_MASK);

  // gated interrupt requests
  always_comb begin
    irq_nxt.critical = (crit_in || wdog_evt) && ms_r[`ESS_MS_CE];
    irq_nxt.external = (ext_in || dec_evt || fit_evt) &&
                       ms_r[`ESS_MS_EXTERNAL_INT_ENABLE];
    irq_nxt.debug = debug_evt && ms_r[`ESS_MS_DBG_IRQ_ENABLE];
    irq_nxt.mchk = mc_pend && cur_mchk_en && !mchk_taken;
  end

  // exception request word
  always_comb begin
    exc_nxt.data_storage = chk_lock;
    exc_nxt.vector_unavail = chk_vec;
    exc_nxt.float_unavail = chk_fpu;
    exc_nxt.program_unimpl = chk_fpi;
    exc_nxt.program_priv = chk_priv;
  end

  // read data, unmapped numbers return zero
  assign rdata_nxt = !reg_acc.rd ? rdata :
                     sel_ms ? ms_r :
                     sel_es ? es_r :
                     sel_mc ? mc_r : 32'h00000000;

  // architectural registers
  always_ff @(posedge clk) begin
    if (srst) begin
      ms_r <= `ESS_MS_RESET;
      es_r <= `ESS_ES_RESET;
      mc_r <= `ESS_MC_RESET;
      mc_pin_prev_r <= 1'b0;
    end else if (ce) begin
      ms_r <= ms_nxt;
      es_r <= es_nxt;
      mc_r <= mc_nxt;
      mc_pin_prev_r <= mc_src.pin;
    end
  end

  // registered outputs; mode and event outputs are taken from the next state, so they change with the registers
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 32'h00000000;
      exc_req <= '0;
      irq_req <= '0;
      mc_event_out <= 1'b0;
      power_save_ok <= 1'b0;
      fetch_space <= 1'b0;
      data_space <= 1'b0;
      user_mode <= 1'b0;
    end else if (ce) begin
      rdata <= rdata_nxt;
      exc_req <= exc_nxt;
      irq_req <= irq_nxt;
      mc_event_out <= |(mc_nxt & `ESS_MC_ASYNC_MASK);
      power_save_ok <= sleep_req && ms_nxt[`ESS_MS_WE];
      fetch_space <= ms_nxt[`ESS_MS_INSTR_ADDR_SPACE];
      data_space <= ms_nxt[`ESS_MS_DATA_ADDR_SPACE];
      user_mode <= ms_nxt[`ESS_MS_USER_MODE_STATE];
    end
  end

endmodule : ess_core_state

// file: hdl/ess_defs.svh
// offsets, field positions, masks and reset values of the state registers
`ifndef ESS_DEFS_SVH
`define ESS_DEFS_SVH

// register numbers on the special-register move port
`define ESS_SPR_EXC_SYNDROME 10'h03E
`define ESS_SPR_MC_SYNDROME 10'h23C

// machine_state fields (architectural bit 0 is hardware bit 31)
`define ESS_MS_USER_CACHE_LOCK_ENABLE 26
`define ESS_MS_VECTOR_SIMD_AVAILABLE 25
`define ESS_MS_WE 18
`define ESS_MS_CE 17
`define ESS_MS_EXTERNAL_INT_ENABLE 15
`define ESS_MS_USER_MODE_STATE 14
`define ESS_MS_FLOAT_AVAILABLE 13
`define ESS_MS_MACHINE_CHECK_ENABLE 12
`define ESS_MS_DBG_IRQ_ENABLE 9
`define ESS_MS_INSTR_ADDR_SPACE 5
`define ESS_MS_DATA_ADDR_SPACE 4
`define ESS_MS_RECOVERABLE_INTERRUPT 1
`define ESS_MS_MASK 32'h0606F232
`define ESS_MS_RESET 32'h00000000

// exc_syndrome fields
`define ESS_ES_PIL 27
`define ESS_ES_PPR 26
`define ESS_ES_PTR 25
`define ESS_ES_FLOAT_OP 24
`define ESS_ES_WRITE_ACCESS_FLAG 23
`define ESS_ES_DCACHE_LOCK_FLAG 21
`define ESS_ES_ICACHE_LOCK_FLAG 20
`define ESS_ES_PUO 18
`define ESS_ES_BYTE_ORDER_FLAG 17
`define ESS_ES_VECTOR_OP 7
`define ESS_ES_ALT_ENCODING 5
`define ESS_ES_MIF 1
`define ESS_ES_MASK 32'h0FB600A2
`define ESS_ES_RESET 32'h00000000

// mc_syndrome fields
`define ESS_MC_PIN 31
`define ESS_MC_ICACHE_DATA_PARITY_ERR 30
`define ESS_MC_HANDLER_FETCH 27
`define ESS_MC_ICACHE_TAG_PARITY_ERR 26
`define ESS_MC_IC_LOCKED_INVAL 24
`define ESS_MC_MASK 32'hCD000000
`define ESS_MC_ASYNC_MASK 32'hCC000000
`define ESS_MC_RESET 32'h00000000

`endif

// file: hdl/ess_pkg.sv
// types shared by the exception state and syndrome block
package ess_pkg;

  // special-register move request from the execute stage
  typedef struct packed {
    logic wr;
    logic rd;
    logic is_state;
    logic [9:0] spr;
    logic [31:0] wdata;
  } ess_reg_acc_type;

  // decoded instruction at the permission check point
  typedef struct packed {
    logic valid;
    logic privileged;
    logic cache_lock;
    logic lock_icache;
    logic vector_op;
    logic float_op;
  } ess_instr_type;

  // storage-side exception events reported by the load/store and fetch units
  typedef struct packed {
    logic align_err;
    logic dsi_access;
    logic dtlb_miss;
    logic byte_order_dsi;
    logic mismatch_isi;
    logic is_store;
  } ess_storage_evt_type;

  // machine check sources
  typedef struct packed {
    logic pin;
    logic ic_data_parity;
    logic ic_tag_parity;
    logic handler_fetch;
    logic locked_inval;
  } ess_mc_src_type;

  // exception requests toward interrupt sequencing
  typedef struct packed {
    logic data_storage;
    logic vector_unavail;
    logic float_unavail;
    logic program_unimpl;
    logic program_priv;
  } ess_exc_req_type;

  // gated asynchronous interrupt requests
  typedef struct packed {
    logic critical;
    logic external;
    logic debug;
    logic mchk;
  } ess_irq_type;

endpackage : ess_pkg

// file: testbench/ess_core_state_sva.sv
// assertion checker for the state and syndrome block
`timescale 1ns/10ps
module ess_core_state_sva
  import ess_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire ess_reg_acc_type reg_acc,
  input wire ess_instr_type instr,
  input wire ess_mc_src_type mc_src,
  input wire logic crit_in,
  input wire logic wdog_evt,
  input wire logic ext_in,
  input wire logic dec_evt,
  input wire logic fit_evt,
  input wire logic debug_evt,
  input wire ess_exc_req_type exc_req,
  input wire ess_irq_type irq_req,
  input wire logic mc_event_out,
  input wire logic user_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // a gated request never appears without its source
  property p_crit; ce && !crit_in && !wdog_evt |=> !irq_req.critical;
  endproperty
  a_crit: assert property (p_crit) else $error("critical unsourced");
  property p_ext; ce && !(ext_in || dec_evt || fit_evt) |=> !irq_req.external;
  endproperty
  a_ext: assert property (p_ext) else $error("external unsourced");
  property p_dbg; ce && !debug_evt |=> !irq_req.debug;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug unsourced");
  property p_mchk; irq_req.mchk |-> mc_event_out || $past(mc_event_out);
  endproperty
  a_mchk: assert property (p_mchk) else $error("mchk not pending");
  // async syndrome sources other than the pin raise the event output within two cycles and it sticks
  property p_async; ce && (mc_src.ic_data_parity || mc_src.ic_tag_parity
    || mc_src.handler_fetch) |-> ##[1:2] mc_event_out;
  endproperty
  a_async: assert property (p_async) else $error("no mc event");
  property p_hold; ce && mc_event_out && !reg_acc.wr && !$past(reg_acc.wr)
    |=> mc_event_out;
  endproperty
  a_hold: assert property (p_hold) else $error("mc event dropped");
  // permission checks on decoded instructions
  property p_priv; ce && instr.valid && instr.privileged && user_mode
    |=> exc_req.program_priv;
  endproperty
  a_priv: assert property (p_priv) else $error("priv not trapped");
  property p_sup; ce && instr.valid && !user_mode |=> !exc_req.program_priv;
  endproperty
  a_sup: assert property (p_sup) else $error("priv trap in sup");
  property p_flt; ce && instr.valid && instr.float_op && !instr.privileged
    && !instr.cache_lock && !instr.vector_op
    |=> exc_req.float_unavail != exc_req.program_unimpl;
  endproperty
  a_flt: assert property (p_flt) else $error("float trap wrong");
endmodule : ess_core_state_sva

bind ess_core_state ess_core_state_sva ess_core_state_sva_inst (
  .clk(clk), .srst(srst), .ce(ce), .reg_acc(reg_acc), .instr(instr),
  .mc_src(mc_src), .crit_in(crit_in), .wdog_evt(wdog_evt), .ext_in(ext_in),
  .dec_evt(dec_evt), .fit_evt(fit_evt), .debug_evt(debug_evt),
  .exc_req(exc_req), .irq_req(irq_req), .mc_event_out(mc_event_out),
  .user_mode(user_mode)
);

// file: testbench/ess_core_state_tb.sv
// self-checking bench for the state and syndrome block
`timescale 1ns/10ps
module ess_core_state_tb
  import ess_pkg::*;
;
  logic clk, srst, ce, mchk_taken, crit_in, wdog_evt, ext_in, dec_evt;
  logic fit_evt, debug_evt, sleep_req, mc_event_out, power_save_ok;
  logic fetch_space, data_space, user_mode;
  logic [31:0] rdata;
  ess_reg_acc_type reg_acc;
  ess_instr_type instr;
  ess_storage_evt_type storage_evt;
  ess_mc_src_type mc_src;
  ess_exc_req_type exc_req;
  ess_irq_type irq_req;
  int miscompares, n_tests;
  localparam logic [9:0] ES = 10'h03E, MC = 10'h23C;
  ess_core_state ess_core_state_inst (.clk(clk), .srst(srst), .ce(ce),
    .reg_acc(reg_acc), .instr(instr), .storage_evt(storage_evt),
    .mc_src(mc_src), .mchk_taken(mchk_taken), .crit_in(crit_in),
    .wdog_evt(wdog_evt), .ext_in(ext_in), .dec_evt(dec_evt),
    .fit_evt(fit_evt), .debug_evt(debug_evt), .sleep_req(sleep_req),
    .rdata(rdata), .exc_req(exc_req), .irq_req(irq_req),
    .mc_event_out(mc_event_out), .power_save_ok(power_save_ok),
    .fetch_space(fetch_space), .data_space(data_space),
    .user_mode(user_mode));
  // compare and count; the bench keeps running after a mismatch
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // every driver below is entered 1 ns after a rising edge; an idle edge
  // after each strobe keeps back-to-back calls from driving one step twice
  task automatic wr(logic m, logic [9:0] s, logic [31:0] d);
    reg_acc = '{1'b1, 1'b0, m, s, d};
    @(posedge clk) #1;
    reg_acc.wr = 1'b0;
    @(posedge clk) #1;
  endtask : wr
  task automatic rd(string nm, logic m, logic [9:0] s, logic [31:0] e);
    reg_acc = '{1'b0, 1'b1, m, s, 32'h0};
    @(posedge clk) #1;
    chk(nm, rdata, e);
    reg_acc.rd = 1'b0;
    @(posedge clk) #1;
  endtask : rd
  task automatic op(logic [5:0] i, logic [4:0] e, logic [31:0] es_exp);
    instr = i;
    @(posedge clk) #1;
    instr = '0;
    chk("exc_req", exc_req, e);
    rd("exc_syndrome", 1'b0, ES, es_exp);
  endtask : op
  task automatic evt(logic [5:0] v, logic [4:0] m, logic [31:0] e);
    storage_evt = v;
    mc_src = m;
    @(posedge clk) #1;
    storage_evt = '0;
    mc_src = '0;
    rd("sydr", 1'b0, (m != 0) ? MC : ES, e);
  endtask : evt
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  // 40 MHz core clock
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // main sequence, one test per block
  initial begin
    srst = 1; ce = 1; sleep_req = 1; mchk_taken = 0;
    {crit_in, wdog_evt, ext_in, dec_evt, fit_evt, debug_evt} = '0;
    reg_acc = '0; instr = '0; storage_evt = '0; mc_src = '0;
    repeat (5) @(posedge clk);
    #1 srst = 0;
    rd("ms", 1'b1, 10'h0, 32'h0);
    rd("es", 1'b0, ES, 32'h0);
    wr(1'b0, 10'h111, 32'hFFFFFFFF);
    rd("unmapped", 1'b0, 10'h111, 32'h0);
    $display("test reset done");
    // all implemented state fields, including user mode, come back
    for (int e = 0; e < 2; e++) begin
      wr(1'b1, 10'h0, e ? 32'hFFFFFFFF : 32'h0);
      chk("modes", {power_save_ok, user_mode}, {e[0], e[0]});
      chk("spaces", {fetch_space, data_space}, {e[0], e[0]});
      for (int k = 0; k < 6; k++) begin
        {crit_in, wdog_evt, ext_in, dec_evt, fit_evt, debug_evt} =
          6'b100000 >> k;
        repeat (2) @(posedge clk);
        #1 chk("irq", irq_req[3:1],
          e ? {k < 2, k > 1 && k < 5, k == 5} : 3'h0);
      end
    end
    {crit_in, wdog_evt, ext_in, dec_evt, fit_evt, debug_evt} = '0;
    rd("ms", 1'b1, 10'h0, 32'h0606F232);
    sleep_req = 0;
    @(posedge clk) #1;
    chk("sleep", power_save_ok, 1'b0);
    sleep_req = 1;
    $display("test state done");
    op(6'h30, 5'h01, 32'h04000000);
    op(6'h21, 5'h02, 32'h01040000);
    op(6'h2C, 5'h00, 32'h01040000);
    wr(1'b1, 10'h0, 32'h00004000);
    op(6'h2C, 5'h10, 32'h00100000);
    op(6'h28, 5'h10, 32'h0);
    op(6'h22, 5'h08, 32'h00000080);
    op(6'h21, 5'h04, 32'h00000000);
    evt(6'h05, 5'h0, 32'h00820000);
    evt(6'h02, 5'h0, 32'h00020000);
    evt(6'h21, 5'h0, 32'h00800000);
    $display("test exceptions done");
    wr(1'b1, 10'h0, 32'h0);
    evt(6'h0, 5'h08, 32'h40000000);
    chk("pend", {mc_event_out, irq_req.mchk}, 2'b10);
    evt(6'h0, 5'h04, 32'h44000000);
    wr(1'b0, MC, 32'h0);
    rd("mcs", 1'b0, MC, 32'h44000000);
    wr(1'b1, 10'h0, 32'h00001002);
    repeat (2) @(posedge clk);
    #1 chk("mchk", irq_req.mchk, 1'b1);
    mchk_taken = 1;
    @(posedge clk) #1;
    mchk_taken = 0;
    rd("ri", 1'b1, 10'h0, 32'h00001000);
    wr(1'b0, MC, 32'h40000000);
    rd("mcs", 1'b0, MC, 32'h04000000);
    wr(1'b0, MC, 32'h04000000);
    evt(6'h0, 5'h01, 32'h01000000);
    evt(6'h0, 5'h02, 32'h09000000);
    evt(6'h0, 5'h10, 32'h89000000);
    wr(1'b0, MC, 32'h88000000);
    repeat (2) @(posedge clk);
    #1 chk("status", {mc_event_out, irq_req.mchk}, 2'b00);
    rd("mcs", 1'b0, MC, 32'h01000000);
    $display("test machine check done");
    // a write while the clock enable is low must leave the state untouched
    ce = 0;
    wr(1'b1, 10'h0, 32'h0);
    ce = 1;
    rd("frozen", 1'b1, 10'h0, 32'h00001000);
    $display("test clock enable done");
    stop_test();
  end
endmodule : ess_core_state_tb
